/* csm_space_manager.v */
// completion space manager: admits non-posted requests against receive space
`include "csm_consts.vh"

// Operation
// - send request only when completions fit
// - read length never above largest request
// - unread largest request means 128 bytes
// - reserve one header per possible completion
// - completions split only on aligned boundaries
// - first completion starts at request address
// - last completion ends at request end
// - middle completions are whole boundary multiples
// - unread boundary means 64 bytes
// - header credits equal spanned boundary blocks
// - merged completions welcome, not required
// - free credits when all completions arrived
module csm_space_manager (
   // clock and reset
   input  wire                     mclk,
   input  wire                     rstn,
   // core configuration outputs and choices
   input  wire                     use_cfg,
   input  wire [2:0]               cfg_max_read_req,
   input  wire [1:0]               cfg_rcb_status,
   input  wire                     func_sel,
   input  wire                     perf_high,
   // request from the user logic
   input  wire                     req_valid,
   input  wire [11:0]              req_addr,
   input  wire [12:0]              req_len,
   input  wire [1:0]               req_type,
   input  wire [`CSM_TAG_BITS-1:0] req_tag,
   output reg                      req_grant,
   output reg                      req_refuse,
   // completion bookkeeping
   input  wire                     cpl_done,
   input  wire [`CSM_TAG_BITS-1:0] cpl_tag,
   output reg                      cpl_stray,
   // credit state
   output reg  [6:0]               header_credits_outstanding,
   output reg  [9:0]               data_credits_outstanding
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_CHECK = 2'h1;
   localparam [1:0] ST_DONE  = 2'h2;

   reg  [1:0]               state;
   reg  [1:0]               next_state;
   reg  [6:0]               need_hdr_q;
   reg  [8:0]               need_data_q;
   reg                      too_long_q;
   reg  [`CSM_TAG_BITS-1:0] tag_q;

   wire [6:0]               calc_hdr;
   wire [8:0]               calc_data;
   wire                     calc_long;
   wire [6:0]               rel_hdr;
   wire [8:0]               rel_data;
   wire [`CSM_TAG_COUNT-1:0] busy;

   reg  [2:0]               mrs_code;
   reg                      rcb_128;
   reg  [9:0]               data_space;
   reg                      release_ok;
   reg  [7:0]               hdr_after;
   reg  [10:0]              data_after;
   reg                      fits;
   reg                      never_fits;
   reg                      grant_now;
   reg                      refuse_now;
   reg  [6:0]               next_hdr;
   reg  [9:0]               next_data;

   // settings in force; without reading the core, assume the small defaults
   always @* begin
      mrs_code   = use_cfg ? cfg_max_read_req : `CSM_MRS_DEFAULT;
      rcb_128    = use_cfg ? cfg_rcb_status[func_sel] : `CSM_RCB_DEFAULT;
      data_space = perf_high ? `CSM_DATA_SPACE_HIGH : `CSM_DATA_SPACE_GOOD;
   end

   csm_credit_calc u_calc (
      .addr_low  (req_addr),
      .len_bytes (req_len),
      .req_type  (req_type),
      .rcb_128   (rcb_128),
      .mrs_code  (mrs_code),
      .need_hdr  (calc_hdr),
      .need_data (calc_data),
      .too_long  (calc_long)
   );

   csm_tag_table u_tags (
      .mclk    (mclk),
      .rstn    (rstn),
      .wr_en   (grant_now),
      .wr_tag  (tag_q),
      .wr_hdr  (need_hdr_q),
      .wr_data (need_data_q),
      .clr_en  (release_ok),
      .clr_tag (cpl_tag),
      .rd_tag  (cpl_tag),
      .rd_hdr  (rel_hdr),
      .rd_data (rel_data),
      .busy    (busy)
   );

   // credits freed by a finished request count only from the next cycle, not toward a grant in the same cycle
   always @* begin
      // one pulse per tag frees it all, so merged completions cost nothing extra
      release_ok = cpl_done & busy[cpl_tag];
      hdr_after  = {1'b0, header_credits_outstanding} + {1'b0, need_hdr_q};
      data_after = {1'b0, data_credits_outstanding} + {2'h0, need_data_q};
      // <= keeps a full pool usable; the core holds exactly this much
      fits       = (hdr_after <= {1'b0, `CSM_HDR_SPACE}) &&
                   (data_after <= {1'b0, data_space});
      // a reservation larger than the whole pool would wait forever
      never_fits = (need_hdr_q > `CSM_HDR_SPACE) ||
                   ({1'b0, need_data_q} > data_space);
      grant_now  = 1'b0;
      refuse_now = 1'b0;
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid)
               next_state = ST_CHECK;
         end
         ST_CHECK: begin
            if (too_long_q || never_fits) begin
               refuse_now = 1'b1;
               next_state = ST_DONE;
            end else if (fits && !busy[tag_q]) begin
               grant_now  = 1'b1;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE; // gives the requester a cycle to drop valid
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // counter update: add on grant, subtract on release, both may coincide
   always @* begin
      next_hdr  = header_credits_outstanding;
      next_data = data_credits_outstanding;
      if (grant_now) begin
         next_hdr  = hdr_after[6:0];
         next_data = data_after[9:0];
      end
      if (release_ok) begin
         next_hdr  = next_hdr - rel_hdr;
         next_data = next_data - {1'b0, rel_data};
      end
   end

   // request capture, state and outputs
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state                      <= ST_IDLE;
         need_hdr_q                 <= 7'h00;
         need_data_q                <= 9'h000;
         too_long_q                 <= 1'b0;
         tag_q                      <= {`CSM_TAG_BITS{1'b0}};
         req_grant                  <= 1'b0;
         req_refuse                 <= 1'b0;
         cpl_stray                  <= 1'b0;
         header_credits_outstanding <= 7'h00;
         data_credits_outstanding   <= 10'h000;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && req_valid) begin
            need_hdr_q  <= calc_hdr;
            need_data_q <= calc_data;
            too_long_q  <= calc_long;
            tag_q       <= req_tag;
         end
         req_grant                  <= grant_now;
         req_refuse                 <= refuse_now;
         cpl_stray                  <= cpl_done & ~busy[cpl_tag];
         header_credits_outstanding <= next_hdr;
         data_credits_outstanding   <= next_data;
      end
   end

endmodule // csm_space_manager

/* csm_consts.vh */
// constants for the completion space manager
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH

// completion space held by the endpoint core, in credits
`define CSM_HDR_SPACE        7'h40
`define CSM_DATA_SPACE_GOOD  10'h1f0
`define CSM_DATA_SPACE_HIGH  10'h3e0

// largest read request encoding
`define CSM_MRS_MAX_CODE     3'h5
`define CSM_MRS_DEFAULT      3'h0
`define CSM_MRS_BASE_BYTES   13'h0080

// read completion boundary
`define CSM_RCB_DEFAULT      1'b0
`define CSM_RCB64_SHIFT      3'h6
`define CSM_RCB128_SHIFT     3'h7

// one data credit covers sixteen bytes
`define CSM_DATA_SHIFT       3'h4

// request kinds
`define CSM_TYPE_MEMRD       2'h0
`define CSM_TYPE_IORD        2'h1
`define CSM_TYPE_IOWR        2'h2
`define CSM_TYPE_OTHER       2'h3

// tag table
`define CSM_TAG_BITS         5
`define CSM_TAG_COUNT        32

`endif

/* csm_credit_calc.v */
// worst-case completion credit need of one non-posted request
`include "csm_consts.vh"

module csm_credit_calc (
   // request
   input  wire [11:0] addr_low,
   input  wire [12:0] len_bytes,
   input  wire [1:0]  req_type,
   // settings in force
   input  wire        rcb_128,
   input  wire [2:0]  mrs_code,
   // result
   output reg  [6:0]  need_hdr,
   output reg  [8:0]  need_data,
   output reg         too_long
);

   // ceiling of sum divided by a power of two
   function [13:0] ceil_div;
      input [13:0] sum;
      input [2:0]  sh;
      reg   [13:0] round;
      begin
         round    = (14'h0001 << sh) - 14'h0001;
         ceil_div = (sum + round) >> sh;
      end
   endfunction

   reg [2:0]  rcb_shift;
   reg [12:0] mrs_bytes;
   reg [13:0] hdr_sum;
   reg [13:0] data_sum;
   reg [13:0] hdr_blocks;
   reg [13:0] data_blocks;

   // completer splits only on boundaries, so each boundary block may cost a header
   always @* begin
      rcb_shift   = rcb_128 ? `CSM_RCB128_SHIFT : `CSM_RCB64_SHIFT;
      hdr_sum     = {2'h0, addr_low & ((12'h001 << rcb_shift) - 12'h001)} + {1'b0, len_bytes};
      data_sum    = {10'h000, addr_low[3:0]} + {1'b0, len_bytes};
      hdr_blocks  = ceil_div(hdr_sum, rcb_shift);
      data_blocks = ceil_div(data_sum, `CSM_DATA_SHIFT);
      // reserved codes fall back to the smallest size, the safe choice
      if (mrs_code > `CSM_MRS_MAX_CODE)
         mrs_bytes = `CSM_MRS_BASE_BYTES;
      else
         mrs_bytes = `CSM_MRS_BASE_BYTES << mrs_code;
      too_long  = 1'b0;
      need_hdr  = 7'h01;
      need_data = 9'h001;
      case (req_type)
         `CSM_TYPE_MEMRD: begin
            too_long  = (len_bytes > mrs_bytes);
            need_hdr  = hdr_blocks[6:0];
            need_data = data_blocks[8:0];
         end
         `CSM_TYPE_IOWR: begin
            need_data = 9'h000; // write answer carries no data
         end
         default: begin
            need_data = 9'h001;
         end
      endcase
   end

endmodule // csm_credit_calc

/* csm_tag_table.v */
// per-tag record of the credits reserved for each outstanding request
`include "csm_consts.vh"

module csm_tag_table (
   // clock and reset
   input  wire                      mclk,
   input  wire                      rstn,
   // allocate
   input  wire                      wr_en,
   input  wire [`CSM_TAG_BITS-1:0]  wr_tag,
   input  wire [6:0]                wr_hdr,
   input  wire [8:0]                wr_data,
   // free
   input  wire                      clr_en,
   input  wire [`CSM_TAG_BITS-1:0]  clr_tag,
   // lookup
   input  wire [`CSM_TAG_BITS-1:0]  rd_tag,
   output wire [6:0]                rd_hdr,
   output wire [8:0]                rd_data,
   output wire [`CSM_TAG_COUNT-1:0] busy
);

   reg [15:0]               slot [0:`CSM_TAG_COUNT-1];
   reg [`CSM_TAG_COUNT-1:0] busy_q;

   // storage needs no reset, the busy bits guard it
   always @(posedge mclk) begin
      if (wr_en)
         slot[wr_tag] <= {wr_hdr, wr_data};
   end

   // a new allocation wins over a free of the same tag
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= {`CSM_TAG_COUNT{1'b0}};
      end else begin
         if (clr_en)
            busy_q[clr_tag] <= 1'b0;
         if (wr_en)
            busy_q[wr_tag] <= 1'b1;
      end
   end

   assign rd_hdr  = slot[rd_tag][15:9];
   assign rd_data = slot[rd_tag][8:0];
   assign busy    = busy_q;

endmodule // csm_tag_table

/* csm_chk.sv */
// port checker for the completion space manager
`include "csm_consts.vh"
module csm_chk (
   // clock and reset
   input logic       mclk,
   input logic       rstn,
   // settings
   input logic       use_cfg,
   input logic [2:0] cfg_max_read_req,
   input logic [1:0] cfg_rcb_status,
   input logic       func_sel,
   input logic       perf_high,
   // request
   input logic        req_valid,
   input logic [11:0] req_addr,
   input logic [12:0] req_len,
   input logic [1:0]  req_type,
   input logic [4:0]  req_tag,
   input logic        req_grant,
   input logic        req_refuse,
   // completions and credits
   input logic       cpl_done,
   input logic [4:0] cpl_tag,
   input logic       cpl_stray,
   input logic [6:0] header_credits_outstanding,
   input logic [9:0] data_credits_outstanding
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // a read above the default request size, taken at its first edge
   sequence s_long_rd;
      $rose(req_valid) && !use_cfg && req_type == 2'h0 && req_len > 13'h0080;
   endsequence
   sequence s_refused;
      ##2 req_refuse;
   endsequence
   property p_long_refused; s_long_rd |-> s_refused; endproperty
   property p_one_answer; req_grant || req_refuse |=> !(req_grant || req_refuse); endproperty
   property p_grant_late; req_grant |-> $past(req_valid, 2); endproperty
   property p_hdr_cap; header_credits_outstanding <= `CSM_HDR_SPACE; endproperty
   property p_data_cap; data_credits_outstanding <= (perf_high ? 10'h3e0 : 10'h1f0); endproperty
   property p_grant_adds;
      req_grant && !$past(cpl_done) |-> header_credits_outstanding > $past(header_credits_outstanding);
   endproperty
   property p_release;
      cpl_done |=> cpl_stray || req_grant || header_credits_outstanding < $past(header_credits_outstanding);
   endproperty
   property p_idle_stray; cpl_done && header_credits_outstanding == 7'h0 |=> cpl_stray; endproperty
   property p_zero; header_credits_outstanding == 7'h0 |-> data_credits_outstanding == 10'h0; endproperty
   a_long_refused: assert property (p_long_refused) else $error("long read not refused");
   a_one_answer: assert property (p_one_answer) else $error("answer not one cycle");
   a_grant_late: assert property (p_grant_late) else $error("grant without request");
   a_hdr_cap: assert property (p_hdr_cap) else $error("header space exceeded");
   a_data_cap: assert property (p_data_cap) else $error("data space exceeded");
   a_grant_adds: assert property (p_grant_adds) else $error("grant reserved nothing");
   a_release: assert property (p_release) else $error("completion freed nothing");
   a_idle_stray: assert property (p_idle_stray) else $error("stray not flagged");
   a_zero: assert property (p_zero) else $error("data held without header");
endmodule // csm_chk
bind csm_space_manager csm_chk u_chk (.*);

/* csm_core_model.sv */
// model of the endpoint core: settings outputs and completion return
module csm_core_model (
   // clock and reset
   input logic       mclk,
   input logic       rstn,
   // bench controls
   input logic       hold,
   input logic       slow,
   input logic       bad,
   input logic [2:0] mrs,
   input logic [1:0] rcb,
   // manager side
   input  logic       req_grant,
   input  logic [4:0] req_tag,
   output logic [2:0] cfg_max_read_req,
   output logic [1:0] cfg_rcb_status,
   output logic       cpl_done,
   output logic [4:0] cpl_tag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] q[$];
   logic [2:0] dl;
   // granted tags queue up; hold lets the bench fill the space
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q.delete();
         dl <= 3'h0;
         cpl_done <= 1'b0;
         cpl_tag <= 5'h00;
         cfg_max_read_req <= 3'h0;
         cfg_rcb_status <= 2'h0;
      end else begin
         cfg_max_read_req <= mrs;
         cfg_rcb_status <= rcb;
         cpl_done <= 1'b0;
         cpl_tag <= ~cpl_tag; // junk between completions, the last tag and its inverse in turn
         if (req_grant) q.push_back(req_tag);
         if (bad) begin
            cpl_done <= 1'b1;
            cpl_tag <= 5'h1f;
         end else if (dl != 3'h0) dl <= dl - 3'h1;
         else if (!hold && q.size() != 0) begin
            // one pulse once every boundary-split completion has landed
            cpl_done <= 1'b1;
            cpl_tag <= q.pop_front();
            dl <= slow ? 3'h5 : 3'h0;
         end
      end
   end
endmodule // csm_core_model

/* tb_top.sv */
// self-checking bench for the completion space manager
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rstn = 0, use_cfg = 0, func_sel = 0, perf_high = 0;
   logic req_valid = 0, hold = 1, slow = 0, bad = 0;
   logic [11:0] req_addr = 0;
   logic [12:0] req_len = 0;
   logic [1:0] req_type = 0, rcb = 0, cfg_rcb_status;
   logic [2:0] mrs = 0, cfg_max_read_req;
   logic [4:0] req_tag = 0, cpl_tag;
   logic req_grant, req_refuse, cpl_done, cpl_stray;
   logic [6:0] header_credits_outstanding;
   logic [9:0] data_credits_outstanding;
   logic [20:0] nq[$], n; // kind, check flag, header, data
   int errors = 0, cmp_count = 0, eh = 0, ed = 0, len;
   always #12.5 mclk = ~mclk;
   csm_space_manager uut (.*);
   csm_core_model u_core (.*);
   task chk(input logic [15:0] s, e, input string nm);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // each answer pulse takes the oldest note
   always @(negedge mclk) if (rstn && (req_grant | req_refuse | cpl_stray)) begin
      n = nq.size() ? nq.pop_front() : 21'h0;
      chk({req_refuse, req_grant, cpl_stray}, n[20:18], "answer");
      if (n[17]) begin
         chk(header_credits_outstanding, n[16:10], "header credits");
         chk(data_credits_outstanding, n[9:0], "data credits");
      end
   end
   // note the outcome, hold fields until answered; st>0 means it must wait st cycles
   task automatic req(input logic [11:0] a, input logic [12:0] l, input logic [1:0] t,
                      input logic [4:0] tg, input int st);
      int r, m, h, d, k, c;
      r = (use_cfg && rcb[func_sel]) ? 128 : 64;
      m = (use_cfg && mrs < 3'h6) ? 128 << mrs : 128;
      h = t == 2'h0 ? (a % r + l + r - 1) / r : 1;
      d = t == 2'h2 ? 0 : t == 2'h0 ? (a % 16 + l + 15) / 16 : 1;
      k = ((t == 2'h0 && l > m) || h > 64) ? 4 : 2;
      c = 0;
      if (k == 2) begin
         eh += h;
         ed += d;
      end
      nq.push_back({k[2:0], hold && st == 0, eh[6:0], ed[9:0]});
      @(negedge mclk);
      {req_addr, req_len, req_type, req_tag, req_valid} = {a, l, t, tg, 1'b1};
      repeat (3000) begin
         @(negedge mclk);
         if (req_grant | req_refuse) break;
         c++;
         if (c == st) begin
            chk(nq.size(), 1, "held request");
            hold = 0;
         end
      end
      chk(c < 3000, 1, "answer in time");
      req_valid = 0;
      @(negedge mclk);
   endtask
   // let every completion return, then expect empty counters
   task drain;
      hold = 0;
      for (int i = 0; i < 400 && header_credits_outstanding !== 7'h0; i++) @(negedge mclk);
      chk(header_credits_outstanding, 0, "header left");
      chk(data_credits_outstanding, 0, "data left");
      {hold, eh, ed} = {1'b1, 64'h0};
   endtask
   initial begin
      #(25 * 20000);
      errors++;
      results;
   end
   initial begin
      void'($urandom(94273));
      repeat (6) @(negedge mclk);
      rstn = 1;
      // defaults: random short reads, boundary crossing, over-long read, other kinds
      for (int i = 0; i < 8; i++) req(12'($urandom), 13'($urandom % 128 + 1), 2'h0, 5'(i), 0);
      req(12'h07c, 13'h0008, 2'h0, 5'h08, 0);
      req(12'h000, 13'h0081, 2'h0, 5'h09, 0);
      for (int t = 1; t < 4; t++) req(12'h000, 13'h0004, 2'(t), 5'(9 + t), 0);
      // tag 0 is still outstanding: the request must wait for its release
      req(12'h000, 13'h0004, 2'h0, 5'h00, 30);
      drain;
      nq.push_back(21'h040000);
      bad = 1;
      @(negedge mclk) bad = 0;
      repeat (3) @(negedge mclk);
      $display("defaults done");
      // every request size code, both functions' boundary bits
      {use_cfg, perf_high, rcb} = 4'hc + 4'h2;
      for (int c = 0; c < 8; c++) begin
         {mrs, func_sel} = {3'(c), c[0]};
         len = c < 6 ? 128 << c : 128;
         req(12'h000, 13'(len), 2'h0, 5'h01, 0);
         req(12'h000, 13'(len + 1), 2'h0, 5'h02, 0);
         drain;
      end
      $display("size codes done");
      // data space at the good level, header space at the high level
      {mrs, rcb, perf_high, slow} = {3'h5, 2'h3, 2'h1};
      req(12'h000, 13'h1000, 2'h0, 5'h01, 0);
      req(12'h000, 13'h1000, 2'h0, 5'h02, 30);
      drain;
      perf_high = 1;
      req(12'h000, 13'h1000, 2'h0, 5'h01, 0);
      req(12'h000, 13'h1000, 2'h0, 5'h02, 0);
      req(12'h000, 13'h1000, 2'h0, 5'h03, 30);
      drain;
      {rcb, slow} = 3'h0;
      req(12'h020, 13'h1000, 2'h0, 5'h04, 0);
      req(12'h000, 13'h1000, 2'h0, 5'h05, 0);
      $display("space limits done");
      // reset in mid-run clears the counters
      rstn = 0;
      repeat (2) @(negedge mclk);
      rstn = 1;
      repeat (2) @(negedge mclk);
      chk(header_credits_outstanding, 0, "header after reset");
      chk(data_credits_outstanding, 0, "data after reset");
      chk(nq.size(), 0, "answers missing");
      $display("reset done");
      results;
   end
endmodule // tb_top
